// ### usb_ep_defs.vh
// Constants for the upstream function endpoint register block.
// Included by the block's design files; holds definitions only.
`ifndef USB_EP_DEFS_VH
`define USB_EP_DEFS_VH

// Register indices; the APB byte address is four times the index.
`define FUNC_ADDR_IDX 8'ha2
`define EP_ENABLES_IDX 8'ha3
`define EP_CONFIG_IDX 8'ha6
`define BUF_INDEX_IDX 8'ha8
`define EP_STATE_IDX 8'haa
`define BUF_PORT_IDX 8'hab
`define COUNT_LOW_IDX 8'hac
`define CPU_COUNT_LOW_IDX 8'hae

// Field positions and widths.
`define FUNC_ADDR_W 7
`define CFG_DEVSEL_LSB 0
`define CFG_DEV1_EN_BIT 4
`define CFG_DEV2_EN_BIT 5
`define CFG_BIG_DEV0_BIT 6
`define IDX_REGION_BIT 2
`define IDX_KEEP_RXFULL_BIT 3
`define IDX_WR_BUSY_BIT 2
`define IDX_RD_BUSY_BIT 3
`define ST_ACK_TX_BIT 0
`define ST_ERR_BIT 1
`define ST_STALL_BIT 2
`define ST_SETUP_BIT 3
`define ST_TOGGLE_BIT 4
`define ST_RXFULL_BIT 5
`define ST_TXEMPTY_BIT 6
`define ST_DIR_BIT 7

// Buffer memory: endpoint (2) + region (1) + byte pointer (6).
`define PTR_W 6
`define MEM_AW 9
`define MEM_DEPTH 512

// Reset values.
`define FUNC_ADDR_RST 7'h00
`define EP_EN_RST 3'h0
`define CFG_RST 5'h00
`define COUNT_RST 8'h00
`endif

// ### ep_buffer_ram.v
// Dual-port byte memory holding the receive and transmit regions of all endpoints.
// Both ports run on pclk; each port reads synchronously, one cycle after its address.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defs.vh"

module ep_buffer_ram (
  input wire pclk,
  input wire a_we,
  input wire [`MEM_AW-1:0] a_addr,
  input wire [7:0] a_wdata,
  output reg [7:0] a_rdata,
  input wire b_we,
  input wire [`MEM_AW-1:0] b_addr,
  input wire [7:0] b_wdata,
  output reg [7:0] b_rdata
);
  reg [7:0] mem [0:`MEM_DEPTH-1];

  always @(posedge pclk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    // The serial engine port wins a same-address collision.
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule // ep_buffer_ram

`default_nettype wire

// ### usb_device_endpoint_regs.v
// APB register block of the upstream USB function: address, endpoint enables,
// buffer sharing, indexed endpoint status, toggle, stall, counts and buffer bytes.
// Assumes a serial interface engine on the same pclk drives the sie_* event ports.
//
// What this block does
// R1 - Seven-bit function address, bit 7 reads zero
// R2 - Endpoint zero always enabled, bit ignored
// R3 - Bits 1-3 enable endpoints 1-3, rest zero
// R4 - Config bit 6 gives buffer to device zero
// R5 - Config: selector, device one/two enables
// R6 - Index bits 0-1 select endpoint, readable
// R7 - Index bit 2 picks receive or transmit
// R8 - Index write with bit 3 low clears rxfull
// R9 - Index read shows buffer write/read busy
// R10 - Status bit 2 write stalls endpoint
// R11 - Status bit 4 holds data toggle
// R12 - Status read: tx ack, error, rx ack
// R13 - Status read: setup, rx full, tx empty
// R14 - Status bit 7 gives transfer direction
// R15 - Data port reads/writes selected buffer bytes
// R16 - Count low reads rx, writes tx count
// R17 - Count low write sets transmit loaded flag
// R18 - CPU count low behaves like count low
// R19 - Byte pointer advances, restarts on index write
// R20 - Reserved bits ignore writes, read zero
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defs.vh"

module usb_device_endpoint_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [6:0] function_address,
  output reg [3:0] ep_enable,
  output reg [1:0] dev_select,
  output reg dev1_enable,
  output reg dev2_enable,
  output reg big_buffer_dev0,
  output reg [3:0] ep_stall,
  output reg [3:0] ep_toggle,
  output reg [3:0] transmit_buffer_loaded_flag,
  output reg [31:0] tx_count_all,
  input wire sie_rx_done,
  input wire sie_tx_done,
  input wire [1:0] sie_ep,
  input wire [7:0] sie_rx_count,
  input wire sie_setup,
  input wire sie_ack,
  input wire sie_error,
  input wire sie_toggle_flip,
  input wire sie_mem_we,
  input wire [`MEM_AW-1:0] sie_mem_addr,
  input wire [7:0] sie_mem_wdata,
  output wire [7:0] sie_mem_rdata
);
  reg [1:0] sel_ep_reg;
  reg region_reg;
  reg [`PTR_W-1:0] ptr_reg;
  reg wait_reg;
  reg wr_busy_reg;
  reg rd_busy_reg;
  reg [3:0] rx_full_reg;
  reg [3:0] ack_tx_reg;
  reg [3:0] err_reg;
  reg [3:0] ack_rx_reg;
  reg [3:0] setup_reg;
  reg [3:0] dir_reg;
  reg [7:0] rx_count_reg [0:3];
  reg [7:0] rd_value;
  reg mapped;
  wire [7:0] idx;
  wire [7:0] wdata;
  wire done;
  wire wr_done;
  wire buf_access;
  wire [7:0] ram_rdata;
  wire [`MEM_AW-1:0] cpu_addr;
  integer i;

  assign idx = paddr[9:2];
  assign wdata = pwdata[7:0];
  // Every access takes exactly one wait state so the buffer byte and the read
  // data can both come from flip-flops without a combinational path to prdata.
  assign pready = wait_reg;
  assign done = psel & penable & wait_reg;
  assign wr_done = done & pwrite & mapped;
  assign pslverr = done & ~mapped;
  assign buf_access = (idx == `BUF_PORT_IDX) & (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);

  // R15 selected region
  assign cpu_addr = {sel_ep_reg, region_reg, ptr_reg};

  always @* begin
    mapped = 1'b0;
    if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
      case (idx)
        `FUNC_ADDR_IDX, `EP_ENABLES_IDX, `EP_CONFIG_IDX, `BUF_INDEX_IDX,
        `EP_STATE_IDX, `BUF_PORT_IDX, `COUNT_LOW_IDX, `CPU_COUNT_LOW_IDX: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  ep_buffer_ram u_ram (
    .pclk(pclk),
    .a_we(wr_done & buf_access),
    .a_addr(cpu_addr),
    .a_wdata(wdata),
    .a_rdata(ram_rdata),
    .b_we(sie_mem_we),
    .b_addr(sie_mem_addr),
    .b_wdata(sie_mem_wdata),
    .b_rdata(sie_mem_rdata)
  );

  // Read mux; ram_rdata is valid in the first access cycle, when prdata is loaded.
  always @* begin
    rd_value = 8'h00;
    case (idx)
      // R1 bit 7 reads zero
      `FUNC_ADDR_IDX: rd_value = {1'b0, function_address};
      // R3 upper bits zero
      `EP_ENABLES_IDX: rd_value = {4'h0, ep_enable};
      // R20 write-only config reads zero
      `EP_CONFIG_IDX: rd_value = 8'h00;
      // R9 busy flags and endpoint
      `BUF_INDEX_IDX: rd_value = {4'h0, rd_busy_reg, wr_busy_reg, sel_ep_reg};
      // R12 acks and error
      `EP_STATE_IDX: begin
        rd_value[`ST_ACK_TX_BIT] = ack_tx_reg[sel_ep_reg];
        rd_value[`ST_ERR_BIT] = err_reg[sel_ep_reg];
        rd_value[`ST_STALL_BIT] = ack_rx_reg[sel_ep_reg];
        // R13 setup, full, empty
        rd_value[`ST_SETUP_BIT] = setup_reg[sel_ep_reg];
        // R11 toggle readback
        rd_value[`ST_TOGGLE_BIT] = ep_toggle[sel_ep_reg];
        rd_value[`ST_RXFULL_BIT] = rx_full_reg[sel_ep_reg];
        rd_value[`ST_TXEMPTY_BIT] = ~transmit_buffer_loaded_flag[sel_ep_reg];
        // R14 direction bit
        rd_value[`ST_DIR_BIT] = dir_reg[sel_ep_reg];
      end
      // R15 buffer byte read
      `BUF_PORT_IDX: rd_value = ram_rdata;
      // R16 receive count low
      `COUNT_LOW_IDX: rd_value = rx_count_reg[sel_ep_reg];
      // R18 same receive count
      `CPU_COUNT_LOW_IDX: rd_value = rx_count_reg[sel_ep_reg];
      default: rd_value = 8'h00;
    endcase
  end

  // APB handshake, read data capture and buffer busy flags.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 1'b0;
      prdata <= 32'h00000000;
      wr_busy_reg <= 1'b0;
      rd_busy_reg <= 1'b0;
    end else begin
      wait_reg <= psel & penable & ~wait_reg;
      if (psel && penable && !wait_reg && !pwrite) begin
        prdata <= mapped ? {24'h000000, rd_value} : 32'h00000000;
      end
      // R9 busy during access
      wr_busy_reg <= psel & penable & ~wait_reg & pwrite & buf_access;
      rd_busy_reg <= psel & penable & ~wait_reg & ~pwrite & buf_access;
    end
  end

  // Global configuration registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_address <= `FUNC_ADDR_RST;
      ep_enable <= {`EP_EN_RST, 1'b1};
      dev_select <= 2'b00;
      dev1_enable <= 1'b0;
      dev2_enable <= 1'b0;
      big_buffer_dev0 <= 1'b0;
    end else if (wr_done) begin
      // R1 seven-bit address
      if (idx == `FUNC_ADDR_IDX) begin
        function_address <= wdata[`FUNC_ADDR_W-1:0];
      end
      // R2 endpoint zero forced on
      if (idx == `EP_ENABLES_IDX) begin
        // R3 endpoints one to three
        ep_enable <= {wdata[3:1], 1'b1};
      end
      // R5 config fields
      if (idx == `EP_CONFIG_IDX) begin
        dev_select <= wdata[`CFG_DEVSEL_LSB+1:`CFG_DEVSEL_LSB];
        dev1_enable <= wdata[`CFG_DEV1_EN_BIT];
        dev2_enable <= wdata[`CFG_DEV2_EN_BIT];
        // R4 buffer owner select
        big_buffer_dev0 <= wdata[`CFG_BIG_DEV0_BIT];
      end
    end
  end

  // Index register and byte pointer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ep_reg <= 2'b00;
      region_reg <= 1'b0;
      ptr_reg <= {`PTR_W{1'b0}};
    end else if (wr_done && idx == `BUF_INDEX_IDX) begin
      // R6 endpoint select
      sel_ep_reg <= wdata[1:0];
      // R7 region select
      region_reg <= wdata[`IDX_REGION_BIT];
      // R19 pointer restart
      ptr_reg <= {`PTR_W{1'b0}};
    end else if (done && buf_access) begin
      // R19 pointer advance
      ptr_reg <= ptr_reg + 1'b1;
    end
  end

  // Per-endpoint state; serial engine events win over a same-cycle CPU write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_stall <= 4'h0;
      ep_toggle <= 4'h0;
      transmit_buffer_loaded_flag <= 4'h0;
      rx_full_reg <= 4'h0;
      ack_tx_reg <= 4'h0;
      err_reg <= 4'h0;
      ack_rx_reg <= 4'h0;
      setup_reg <= 4'h0;
      dir_reg <= 4'h0;
      tx_count_all <= 32'h00000000;
      for (i = 0; i < 4; i = i + 1) begin
        rx_count_reg[i] <= `COUNT_RST;
      end
    end else begin
      if (wr_done) begin
        // R8 clear receive full
        if (idx == `BUF_INDEX_IDX && !wdata[`IDX_KEEP_RXFULL_BIT]) begin
          rx_full_reg[wdata[1:0]] <= 1'b0;
        end
        if (idx == `EP_STATE_IDX) begin
          // R10 stall on write
          ep_stall[sel_ep_reg] <= wdata[`ST_STALL_BIT];
          // R11 toggle set
          ep_toggle[sel_ep_reg] <= wdata[`ST_TOGGLE_BIT];
        end
        if (idx == `COUNT_LOW_IDX || idx == `CPU_COUNT_LOW_IDX) begin
          // R16 transmit count low
          tx_count_all[sel_ep_reg*8 +: 8] <= wdata;
          // R17 mark transmit loaded
          transmit_buffer_loaded_flag[sel_ep_reg] <= 1'b1;
        end
      end
      if (sie_toggle_flip) begin
        ep_toggle[sie_ep] <= ~ep_toggle[sie_ep];
      end
      if (sie_rx_done) begin
        // R13 receive events set
        rx_full_reg[sie_ep] <= 1'b1;
        setup_reg[sie_ep] <= sie_setup;
        rx_count_reg[sie_ep] <= sie_rx_count;
        // R12 receive ack and error
        ack_rx_reg[sie_ep] <= sie_ack;
        err_reg[sie_ep] <= sie_error;
        // R14 OUT direction
        dir_reg[sie_ep] <= 1'b0;
      end else if (sie_tx_done) begin
        // R13 transmit emptied
        transmit_buffer_loaded_flag[sie_ep] <= 1'b0;
        ack_tx_reg[sie_ep] <= sie_ack;
        err_reg[sie_ep] <= sie_error;
        // R14 IN direction
        dir_reg[sie_ep] <= 1'b1;
      end
    end
  end
endmodule // usb_device_endpoint_regs

`default_nettype wire

// ### ep_regs_props.sv
// Port checks for the endpoint register block.
// Assumes an APB master with one request at a time and an engine on pclk.
`timescale 1ns/1ps
`default_nettype none
module ep_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] function_address,
  input wire logic [3:0] ep_enable,
  input wire logic [3:0] transmit_buffer_loaded_flag,
  input wire logic sie_rx_done,
  input wire logic sie_tx_done,
  input wire logic [1:0] sie_ep
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] sel_reg;
  wire wr_done = psel && penable && pready && pwrite;
  // The checker keeps its own copy of the selected endpoint.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 2'h0;
    end else if (wr_done && paddr == 12'h2a0) begin
      sel_reg <= pwdata[1:0];
    end
  end
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state count wrong");
  chk_idle_quiet: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without request");
  chk_ep0_always: assert property (ep_enable[0])
    else $error("endpoint zero disabled");
  chk_addr_held: assert property (wr_done && paddr == 12'h288 |=> function_address == $past(pwdata[6:0]))
    else $error("function address not loaded");
  chk_enable_bits: assert property (wr_done && paddr == 12'h28c |=> ep_enable[3:1] == $past(pwdata[3:1]))
    else $error("endpoint enables not loaded");
  chk_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_map_error: assert property (pready |->
    pslverr == !(paddr[9:2] inside {8'ha2, 8'ha3, 8'ha6, 8'ha8, 8'haa, 8'hab, 8'hac, 8'hae}))
    else $error("error response wrong");
  chk_count_loads: assert property (wr_done && (paddr == 12'h2b0 || paddr == 12'h2b8) && !sie_tx_done
    |=> transmit_buffer_loaded_flag[sel_reg])
    else $error("loaded flag not set");
  chk_tx_clears: assert property (sie_tx_done && !sie_rx_done |=> !transmit_buffer_loaded_flag[$past(sie_ep)])
    else $error("loaded flag not cleared");
  cov_slverr: cover property (pready && pslverr);
  cov_tx_done: cover property (sie_tx_done);
  cov_count_write: cover property (wr_done && paddr == 12'h2b8);
endmodule // ep_regs_props
bind usb_device_endpoint_regs ep_regs_props ep_regs_props_inst (.*);
`default_nettype wire

// ### sie_model.sv
// Stand-in for the serial engine: one-cycle event pulses on pclk.
// The buffer port is driven only by the mem task; qualifiers are scrambled between events.
`timescale 1ns/1ps
`default_nettype none
module sie_model (
  input wire logic pclk,
  output logic sie_rx_done,
  output logic sie_tx_done,
  output logic [1:0] sie_ep,
  output logic [7:0] sie_rx_count,
  output logic sie_setup,
  output logic sie_ack,
  output logic sie_error,
  output logic sie_toggle_flip,
  output logic sie_mem_we,
  output logic [8:0] sie_mem_addr,
  output logic [7:0] sie_mem_wdata,
  input wire logic [7:0] sie_mem_rdata
);
  initial begin
    {sie_rx_done, sie_tx_done, sie_ep, sie_rx_count, sie_setup, sie_ack, sie_error} = 15'h0;
    {sie_toggle_flip, sie_mem_we, sie_mem_addr, sie_mem_wdata} = 19'h0;
  end
  // Flags f are setup, ack, error and toggle flip.
  task ev(input logic r, input logic t, input logic [1:0] e, input logic [7:0] c, input logic [3:0] f);
    @(posedge pclk);
    {sie_rx_done, sie_tx_done, sie_ep, sie_rx_count} <= {r, t, e, c};
    {sie_setup, sie_ack, sie_error, sie_toggle_flip} <= f;
    @(posedge pclk);
    {sie_rx_done, sie_tx_done, sie_toggle_flip} <= 3'h0;
    {sie_ep, sie_rx_count, sie_setup, sie_ack, sie_error} <= ~{e, c, f[3:1]};
    #1;
  endtask
  // Buffer port access; the byte read comes back one cycle after the address is taken.
  task mem(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge pclk);
    {sie_mem_we, sie_mem_addr, sie_mem_wdata} <= {w, a, d};
    @(posedge pclk);
    sie_mem_we <= 1'h0;
    @(posedge pclk);
    r = sie_mem_rdata;
    #1;
  endtask
endmodule // sie_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the endpoint register block.
// Drives APB and the engine model; waits up to 20 cycles for pready on each transfer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] q;
  int n_errors = 0, tests_run = 0;
  wire [31:0] prdata, tx_count_all;
  wire pready, pslverr, dev1_enable, dev2_enable, big_buffer_dev0, sie_rx_done, sie_tx_done;
  wire sie_setup, sie_ack, sie_error, sie_toggle_flip, sie_mem_we;
  wire [6:0] function_address;
  wire [3:0] ep_enable, ep_stall, ep_toggle, transmit_buffer_loaded_flag;
  wire [1:0] dev_select, sie_ep;
  wire [7:0] sie_rx_count, sie_mem_wdata, sie_mem_rdata;
  wire [8:0] sie_mem_addr;
  // Rows: register index, value written, value read back.
  logic [23:0] rows [0:4] = '{24'ha2ff7f, 24'ha3f001, 24'ha30e0f, 24'ha67f00, 24'ha8f703};
  usb_device_endpoint_regs usb_device_endpoint_regs_inst (.*);
  sie_model sie_model_inst (.*);
  always #4 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, 2'h0, a, 2'h0, 24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++k < 20);
    // A transfer that never completes counts as a mismatch.
    if (pready !== 1'h1) begin
      n_errors++;
    end
    q = prdata[7:0];
    e = pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task complete_run;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #16000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    chk(function_address, 7'h0);
    chk(ep_enable, 4'h1);
    foreach (rows[i]) begin
      apb(1'h1, rows[i][23:16], rows[i][15:8]);
      apb(1'h0, rows[i][23:16], 8'h0);
      chk(q, rows[i][7:0]);
    end
    apb(1'h1, 8'ha6, 8'h31);
    chk({big_buffer_dev0, dev2_enable, dev1_enable, dev_select}, 5'h0d);
    apb(1'h1, 8'ha6, 8'h40);
    chk({big_buffer_dev0, dev2_enable, dev1_enable, dev_select}, 5'h10);
    sie_model_inst.ev(1'h1, 1'h0, 2'h1, 8'h05, 4'hc);
    apb(1'h1, 8'ha8, 8'h09);
    apb(1'h0, 8'haa, 8'h0);
    chk(q, 8'h6c);
    apb(1'h0, 8'hac, 8'h0);
    chk(q, 8'h05);
    apb(1'h0, 8'hae, 8'h0);
    chk(q, 8'h05);
    apb(1'h1, 8'ha8, 8'h01);
    apb(1'h0, 8'haa, 8'h0);
    chk(q & 8'h20, 8'h0);
    apb(1'h1, 8'hac, 8'h20);
    chk(transmit_buffer_loaded_flag, 4'h2);
    chk(tx_count_all, 32'h2000);
    apb(1'h0, 8'haa, 8'h0);
    chk(q & 8'h40, 8'h0);
    sie_model_inst.ev(1'h0, 1'h1, 2'h1, 8'h0, 4'h4);
    chk(transmit_buffer_loaded_flag, 4'h0);
    apb(1'h0, 8'haa, 8'h0);
    chk(q & 8'hc3, 8'hc1);
    apb(1'h1, 8'hae, 8'h07);
    chk(tx_count_all, 32'h0700);
    chk(transmit_buffer_loaded_flag, 4'h2);
    apb(1'h1, 8'haa, 8'h14);
    chk({ep_stall, ep_toggle}, 8'h22);
    sie_model_inst.ev(1'h0, 1'h0, 2'h1, 8'h0, 4'h1);
    chk(ep_toggle, 4'h0);
    apb(1'h0, 8'haa, 8'h0);
    chk(q & 8'h10, 8'h0);
    apb(1'h1, 8'ha8, 8'h05);
    apb(1'h1, 8'hab, 8'haa);
    apb(1'h1, 8'hab, 8'h55);
    apb(1'h1, 8'ha8, 8'h0d);
    apb(1'h0, 8'hab, 8'h0);
    chk(q, 8'haa);
    apb(1'h0, 8'hab, 8'h0);
    chk(q, 8'h55);
    apb(1'h1, 8'ha4, 8'h01);
    chk(e, 1'h1);
    sie_model_inst.mem(1'h1, 9'h100, 8'h3c, q);
    apb(1'h1, 8'ha8, 8'h0a);
    apb(1'h0, 8'hab, 8'h0);
    chk(q, 8'h3c);
    sie_model_inst.mem(1'h0, 9'h0c0, 8'h0, q);
    chk(q, 8'haa);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    #1;
    chk(function_address, 7'h0);
    chk(ep_enable, 4'h1);
    chk(transmit_buffer_loaded_flag, 4'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'ha2, 8'h0);
    chk(q, 8'h00);
    complete_run;
  end
endmodule // tb
`default_nettype wire
